// >>> rtl/vcp_pkg.sv
// package for the vector control parameter register slice
// assumes a byte-wide register port on one 40 MHz clock domain
package vcp_pkg;

    // ==================================================================
    // register addresses (high byte at the pair base, low byte at +1)
    // ==================================================================
    localparam logic [15:0] VCP_ADDR_ALPHA_HI = 16'h40c4;
    localparam logic [15:0] VCP_ADDR_FLUX_HI  = 16'h40c6;
    localparam logic [15:0] VCP_ADDR_LQ_HI    = 16'h40c8;
    localparam logic [15:0] VCP_ADDR_LD_HI    = 16'h40ca;
    localparam logic [15:0] VCP_ADDR_ANGLE_HI = 16'h40cc;
    localparam logic [15:0] VCP_ADDR_LO_STEP  = 16'h0001;

    // ==================================================================
    // parameter store layout and values
    // ==================================================================
    localparam int          VCP_PARAM_WORDS  = 4;
    localparam logic [1:0]  VCP_IDX_ALPHA    = 2'h0;
    localparam logic [1:0]  VCP_IDX_FLUX     = 2'h1;
    localparam logic [1:0]  VCP_IDX_LQ       = 2'h2;
    localparam logic [1:0]  VCP_IDX_LD       = 2'h3;
    localparam logic [15:0] VCP_RST_WORD     = 16'h0000;
    localparam logic [7:0]  VCP_RST_BYTE     = 8'h00;
    localparam logic [15:0] VCP_PARAM_MAX    = 16'h7fff;
    localparam logic [7:0]  VCP_UNMAPPED_RD  = 8'h00;

    // ==================================================================
    // angle encoding: 32768 counts per half turn, msb pair is quadrant
    // ==================================================================
    localparam logic [16:0] VCP_ANGLE_HALF_TURN = 17'h08000;
    localparam int          VCP_QUAD_MSB        = 15;
    localparam int          VCP_QUAD_LSB        = 14;

    // ==================================================================
    // carriers
    // ==================================================================
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } vcp_bus_req_s;

    typedef struct packed {
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] c;
    } vcp_phase_s;

    typedef struct packed {
        logic [15:0] alpha;
        logic [15:0] flux;
        logic [15:0] lq;
        logic [15:0] ld;
    } vcp_param_s;

endpackage

// >>> rtl/vcp_param_store.sv
// byte-writable store of 16-bit parameter words with registered outputs
// assumes one write per cycle from the register decoder on the same clock
`timescale 1ns/1ps

module vcp_param_store
    import vcp_pkg::*;
#(
    parameter int WORDS = VCP_PARAM_WORDS
)(
    input  wire logic                    sys_clk,
    input  wire logic                    rst_n,
    input  wire logic                    wr_en,
    input  wire logic [1:0]              wr_idx,
    input  wire logic                    wr_hi,
    input  wire logic [7:0]              wr_byte,
    output      logic [WORDS-1:0][15:0]  words
);

    // ==================================================================
    // elaboration check: index is two bits wide
    // ==================================================================
    if (WORDS < 1 || WORDS > 4)
    begin : g_bad_words
        $error("vcp_param_store: WORDS must be 1 to 4");
    end

    typedef struct packed {
        logic [WORDS-1:0][15:0] mem;
    } vcp_store_state_s;

    vcp_store_state_s       st_reg;
    vcp_store_state_s       st_next;
    logic [WORDS-1:0][15:0] word_next;

    // ==================================================================
    // per-entry byte update, high byte first in the address pair
    // ==================================================================
    for (genvar i = 0; i < WORDS; i++)
    begin : g_entry
        logic hit;
        assign hit = wr_en && (wr_idx == 2'(i));
        assign word_next[i][15:8] = (hit && wr_hi)  ? wr_byte
                                                    : st_reg.mem[i][15:8];
        assign word_next[i][7:0]  = (hit && !wr_hi) ? wr_byte
                                                    : st_reg.mem[i][7:0];
    end

    // next state is just the per-entry results
    always_comb
    begin
        st_next     = st_reg;
        st_next.mem = word_next;
    end

    // all words clear at reset
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            st_reg.mem <= '{default: VCP_RST_WORD};
        else
            st_reg <= st_next;
    end

    assign words = st_reg.mem;

endmodule // vcp_param_store

// >>> rtl/vcp_regs.sv
// vector control parameter and phase current register slice
// assumes byte register port and engine signals on sys_clk, no sync needed
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps

module vcp_regs
    import vcp_pkg::*;
(
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire vcp_bus_req_s bus_req,
    output      logic [7:0]   rd_data,
    input  wire vcp_phase_s   phase_current,
    input  wire logic         angle_upd,
    input  wire logic [15:0]  angle_in,
    output      vcp_param_s   params,
    output      logic [15:0]  electrical_angle,
    output      logic [1:0]   angle_quadrant,
    output      logic         flux_ok,
    output      logic         q_inductance_ok,
    output      logic         d_inductance_ok
);

    // ==================================================================
    // state of this module
    // ==================================================================
    typedef struct packed {
        logic [7:0]  rd_data;
        logic [7:0]  rd_shadow;
        logic [15:0] angle;
        logic [1:0]  quadrant;
        logic        flux_ok;
        logic        lq_ok;
        logic        ld_ok;
    } vcp_top_state_s;

    vcp_top_state_s                 st_reg;
    vcp_top_state_s                 st_next;
    logic [VCP_PARAM_WORDS-1:0][15:0] store_words;
    logic                           store_wr;
    logic [1:0]                     store_idx;
    logic                           store_hi;
    logic                           addr_alpha;
    logic                           addr_flux;
    logic                           addr_lq;
    logic                           addr_ld;
    logic                           addr_angle;
    logic                           addr_hi;
    logic [15:0]                    pair_base;

    // ==================================================================
    // elaboration checks on the package constants
    // ==================================================================
    // the decode folds odd addresses onto the even pair base
    if (VCP_ADDR_ALPHA_HI[0] || VCP_ADDR_FLUX_HI[0] || VCP_ADDR_LQ_HI[0]
        || VCP_ADDR_LD_HI[0] || VCP_ADDR_ANGLE_HI[0])
    begin : g_odd_base
        $error("vcp_regs: register pairs must start on even addresses");
    end

    // overlapping pairs would let one write land in two words
    if (VCP_ADDR_ALPHA_HI == VCP_ADDR_FLUX_HI
        || VCP_ADDR_FLUX_HI == VCP_ADDR_LQ_HI
        || VCP_ADDR_LQ_HI == VCP_ADDR_LD_HI
        || VCP_ADDR_LD_HI == VCP_ADDR_ANGLE_HI)
    begin : g_overlap
        $error("vcp_regs: register pairs must not share a base");
    end

    // low byte sits exactly one address above the high byte
    if (VCP_ADDR_LO_STEP != 16'h0001)
    begin : g_bad_step
        $error("vcp_regs: low byte step must be one");
    end

    // one store entry per write-only word of the parameter carrier
    if (VCP_PARAM_WORDS != $bits(vcp_param_s) / 16)
    begin : g_bad_words
        $error("vcp_regs: store depth must match the parameter carrier");
    end

    // every index must name its own entry of the store
    if (VCP_IDX_ALPHA == VCP_IDX_FLUX || VCP_IDX_ALPHA == VCP_IDX_LQ
        || VCP_IDX_ALPHA == VCP_IDX_LD || VCP_IDX_FLUX == VCP_IDX_LQ
        || VCP_IDX_FLUX == VCP_IDX_LD || VCP_IDX_LQ == VCP_IDX_LD)
    begin : g_bad_index
        $error("vcp_regs: store indices must be distinct");
    end

    // quadrant is the top two bits of the angle word
    if (VCP_QUAD_MSB != $bits(angle_in) - 1
        || VCP_QUAD_LSB != VCP_QUAD_MSB - 1)
    begin : g_bad_quadrant
        $error("vcp_regs: quadrant must be the two top angle bits");
    end

    // half a turn must be the weight of the sign bit
    if (VCP_ANGLE_HALF_TURN != (17'h00001 << VCP_QUAD_MSB))
    begin : g_bad_half_turn
        $error("vcp_regs: half turn must match the angle sign bit");
    end

    // idle read byte equals the reset byte, so no step after reset
    if (VCP_UNMAPPED_RD != VCP_RST_BYTE)
    begin : g_bad_idle
        $error("vcp_regs: idle read byte must equal the reset byte");
    end

    // ==================================================================
    // address decode: pair base and byte lane
    // ==================================================================
    // the low byte sits one address above the high byte
    always_comb
    begin
        addr_hi   = (bus_req.addr[0] == 1'b0);
        pair_base = addr_hi ? bus_req.addr
                            : bus_req.addr - VCP_ADDR_LO_STEP;
        addr_alpha = (pair_base == VCP_ADDR_ALPHA_HI);
        addr_flux  = (pair_base == VCP_ADDR_FLUX_HI);
        addr_lq    = (pair_base == VCP_ADDR_LQ_HI);
        addr_ld    = (pair_base == VCP_ADDR_LD_HI);
        addr_angle = (pair_base == VCP_ADDR_ANGLE_HI);
    end

    // ==================================================================
    // write path into the write-only parameter store
    // ==================================================================
    // parameter writes only; shared addresses never touch the currents
    // no staging: between the two byte writes the engine sees a mixed
    // word, so software updates a live parameter at its own risk
    always_comb
    begin
        store_wr  = 1'b0;
        store_idx = VCP_IDX_ALPHA;
        store_hi  = addr_hi;
        if (bus_req.wr)
        begin
            if (addr_alpha)
            begin
                store_wr  = 1'b1;
                store_idx = VCP_IDX_ALPHA;
            end
            else if (addr_flux)
            begin
                store_wr  = 1'b1;
                store_idx = VCP_IDX_FLUX;
            end
            else if (addr_lq)
            begin
                store_wr  = 1'b1;
                store_idx = VCP_IDX_LQ;
            end
            else if (addr_ld)
            begin
                store_wr  = 1'b1;
                store_idx = VCP_IDX_LD;
            end
        end
    end

    // word store, cleared at reset
    vcp_param_store #(
        .WORDS   (VCP_PARAM_WORDS)
    ) u_store (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .wr_en   (store_wr),
        .wr_idx  (store_idx),
        .wr_hi   (store_hi),
        .wr_byte (bus_req.wdata),
        .words   (store_words)
    );

    // ==================================================================
    // range check helper: open range zero to 32767
    // ==================================================================
    function automatic logic vcp_in_range(input logic [15:0] v);
        logic ok;
        ok = (v != VCP_RST_WORD) && (v[15] == 1'b0)
             && (v != VCP_PARAM_MAX);
        return ok;
    endfunction

    // ==================================================================
    // next-state logic
    // ==================================================================
    always_comb
    begin
        st_next = st_reg;

        // read data stands only in the cycle after the read strobe
        st_next.rd_data = VCP_UNMAPPED_RD;

        // engine result first so that a software write can override it
        // a byte write splits the word: the other byte takes angle_in
        if (angle_upd)
            st_next.angle = angle_in;

        // software access to the angle word
        if (bus_req.wr && addr_angle)
        begin
            if (addr_hi)
                st_next.angle[15:8] = bus_req.wdata;
            else
                st_next.angle[7:0] = bus_req.wdata;
        end

        // read mux: currents share addresses with write-only parameters
        // high byte read captures the low byte so the pair is coherent
        // one shadow serves all pairs: another high read between the
        // two halves hands the low read a byte of a different word
        if (bus_req.rd)
        begin
            if (addr_flux)
            begin
                if (addr_hi)
                begin
                    st_next.rd_data   = phase_current.c[15:8];
                    st_next.rd_shadow = phase_current.c[7:0];
                end
                else
                    st_next.rd_data   = st_reg.rd_shadow;
            end
            else if (addr_lq)
            begin
                if (addr_hi)
                begin
                    st_next.rd_data   = phase_current.b[15:8];
                    st_next.rd_shadow = phase_current.b[7:0];
                end
                else
                    st_next.rd_data   = st_reg.rd_shadow;
            end
            else if (addr_ld)
            begin
                if (addr_hi)
                begin
                    st_next.rd_data   = phase_current.a[15:8];
                    st_next.rd_shadow = phase_current.a[7:0];
                end
                else
                    st_next.rd_data   = st_reg.rd_shadow;
            end
            else if (addr_angle)
            begin
                if (addr_hi)
                begin
                    st_next.rd_data   = st_reg.angle[15:8];
                    st_next.rd_shadow = st_reg.angle[7:0];
                end
                else
                    st_next.rd_data   = st_reg.rd_shadow;
            end
            // alpha pair is write-only and reads as zero
        end

        // quadrant follows the linear half-turn scale
        // 00: 0..90, 01: 90..180, 10: -180..-90, 11: -90..0 degrees
        st_next.quadrant = st_next.angle[VCP_QUAD_MSB:VCP_QUAD_LSB];

        // parameter sanity, one cycle behind the store
        st_next.flux_ok = vcp_in_range(store_words[VCP_IDX_FLUX]);
        st_next.lq_ok   = vcp_in_range(store_words[VCP_IDX_LQ]);
        st_next.ld_ok   = vcp_in_range(store_words[VCP_IDX_LD]);
    end

    // ==================================================================
    // state register, everything clears to zero
    // ==================================================================
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg.rd_data   <= VCP_RST_BYTE;
            st_reg.rd_shadow <= VCP_RST_BYTE;
            st_reg.angle     <= VCP_RST_WORD;
            st_reg.quadrant  <= 2'h0;
            st_reg.flux_ok   <= 1'b0;
            st_reg.lq_ok     <= 1'b0;
            st_reg.ld_ok     <= 1'b0;
        end
        else
            st_reg <= st_next;
    end

    // ==================================================================
    // outputs, all straight from flops
    // ==================================================================
    assign rd_data          = st_reg.rd_data;
    assign electrical_angle = st_reg.angle;
    assign angle_quadrant   = st_reg.quadrant;
    assign flux_ok          = st_reg.flux_ok;
    assign q_inductance_ok  = st_reg.lq_ok;
    assign d_inductance_ok  = st_reg.ld_ok;
    assign params.alpha     = store_words[VCP_IDX_ALPHA];
    assign params.flux      = store_words[VCP_IDX_FLUX];
    assign params.lq        = store_words[VCP_IDX_LQ];
    assign params.ld        = store_words[VCP_IDX_LD];

endmodule // vcp_regs

// >>> dv/vcp_regs_sva.sv
// checker for the parameter register slice, ports of vcp_regs only
// assumes one sys_clk domain and an active-low asynchronous rst_n
`timescale 1ns/1ps

module vcp_regs_sva
    import vcp_pkg::*;
(
    input wire logic         sys_clk,
    input wire logic         rst_n,
    input wire vcp_bus_req_s bus_req,
    input wire logic [7:0]   rd_data,
    input wire vcp_phase_s   phase_current,
    input wire logic         angle_upd,
    input wire logic [15:0]  angle_in,
    input wire vcp_param_s   params,
    input wire logic [15:0]  electrical_angle
);
    // ==================================================================
    // clocking and strobe sequences
    // ==================================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_wr(logic [15:0] a);
        bus_req.wr && bus_req.addr == a;
    endsequence

    sequence s_rd(logic [15:0] a);
        bus_req.rd && bus_req.addr == a;
    endsequence

    // ==================================================================
    // write side: each byte lands one cycle after its strobe
    // ==================================================================
    a_alpha_hi_load: assert property (s_wr(16'h40c4) |=>
        params.alpha[15:8] == $past(bus_req.wdata))
        else $error("alpha high byte not loaded");
    a_flux_lo_load: assert property (s_wr(16'h40c7) |=>
        params.flux[7:0] == $past(bus_req.wdata))
        else $error("flux low byte not loaded");
    a_lq_lo_load: assert property (s_wr(16'h40c9) |=>
        params.lq[7:0] == $past(bus_req.wdata))
        else $error("q inductance low byte not loaded");
    a_ld_hi_load: assert property (s_wr(16'h40ca) |=>
        params.ld[15:8] == $past(bus_req.wdata))
        else $error("d inductance high byte not loaded");
    a_angle_lo_load: assert property (s_wr(16'h40cd) |=>
        electrical_angle[7:0] == $past(bus_req.wdata))
        else $error("angle low byte not loaded");
    // engine update loses only to a software write of the angle pair
    a_angle_engine: assert property (angle_upd &&
        !(bus_req.wr && bus_req.addr[15:1] == 15'h2066)
        |=> electrical_angle == $past(angle_in))
        else $error("engine angle not taken");

    // ==================================================================
    // read side: shared addresses answer with currents
    // ==================================================================
    a_alpha_no_read: assert property (s_rd(16'h40c4) |=>
        rd_data == 8'h00)
        else $error("alpha pair readable");
    a_phase_c_hi: assert property (s_rd(16'h40c6) |=>
        rd_data == $past(phase_current.c[15:8]))
        else $error("phase c high byte wrong");
    a_phase_b_hi: assert property (s_rd(16'h40c8) |=>
        rd_data == $past(phase_current.b[15:8]))
        else $error("phase b high byte wrong");
    a_phase_a_hi: assert property (s_rd(16'h40ca) |=>
        rd_data == $past(phase_current.a[15:8]))
        else $error("phase a high byte wrong");
    // low byte belongs to the value seen at the high read
    a_pair_coherent: assert property (
        s_rd(16'h40c6) ##1 s_rd(16'h40c7)
        |=> rd_data == $past(phase_current.c[7:0], 2))
        else $error("phase c word torn");
endmodule // vcp_regs_sva

bind vcp_regs vcp_regs_sva u_sva (
    .sys_clk          (sys_clk),
    .rst_n            (rst_n),
    .bus_req          (bus_req),
    .rd_data          (rd_data),
    .phase_current    (phase_current),
    .angle_upd        (angle_upd),
    .angle_in         (angle_in),
    .params           (params),
    .electrical_angle (electrical_angle)
);

// >>> dv/test_vcp_regs.sv
// self-checking bench for the parameter register slice
// assumes vcp_regs alone, ports driven directly by the bench
`timescale 1ns/1ps

module test_vcp_regs
    import vcp_pkg::*;
;
    // ==================================================================
    // stimulus and observed signals
    // ==================================================================
    logic         sys_clk = 1'b0;
    logic         rst_n = 1'b0;
    vcp_bus_req_s bus_req = '0;
    logic [7:0]   rd_data;
    vcp_phase_s   phase_current = '0;
    logic         angle_upd = 1'b0;
    logic [15:0]  angle_in = 16'h0000;
    vcp_param_s   params;
    logic [15:0]  electrical_angle;
    logic [1:0]   angle_quadrant;
    logic         flux_ok;
    logic         q_inductance_ok;
    logic         d_inductance_ok;
    logic [2:0]   oks;
    int           num_errors = 0;
    int           n_checks = 0;
    logic [15:0]  vals [5] = '{16'h0000, 16'h0001, 16'h7ffe, 16'h7fff,
                               16'h8000};
    logic [4:0]   vals_ok = 5'h06; // open range zero to 32767, per value
    logic [15:0]  angs [4] = '{16'h2000, 16'h6000, 16'ha000, 16'he000};

    assign oks = {flux_ok, q_inductance_ok, d_inductance_ok};

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    vcp_regs dut (
        .sys_clk          (sys_clk),
        .rst_n            (rst_n),
        .bus_req          (bus_req),
        .rd_data          (rd_data),
        .phase_current    (phase_current),
        .angle_upd        (angle_upd),
        .angle_in         (angle_in),
        .params           (params),
        .electrical_angle (electrical_angle),
        .angle_quadrant   (angle_quadrant),
        .flux_ok          (flux_ok),
        .q_inductance_ok  (q_inductance_ok),
        .d_inductance_ok  (d_inductance_ok)
    );

    // ==================================================================
    // bus cycles and comparison
    // ==================================================================
    task automatic chk(input string w, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        bus_req.wr <= 1'b0;
    endtask

    // high byte first, the order software uses for a whole word
    task automatic wr16(input logic [15:0] a, input logic [15:0] v);
        wr(a, v[15:8]);
        wr(a + 16'h0001, v[7:0]);
        #1;
    endtask

    // flip inverts the currents in the cycle of this read
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e,
                         input logic flip);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        if (flip)
            phase_current <= ~phase_current;
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1;
        chk("read byte", {8'h00, e}, {8'h00, rd_data});
    endtask

    // whole word, high then low with no gap; flip inverts the currents
    // as the low read is issued
    task automatic rd16chk(input logic [15:0] a, input logic [15:0] e,
                           input logic flip);
        @(posedge sys_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        bus_req.addr <= a + 16'h0001;
        if (flip)
            phase_current <= ~phase_current;
        #1;
        chk("read high", {8'h00, e[15:8]}, {8'h00, rd_data});
        @(posedge sys_clk);
        bus_req.rd <= 1'b0;
        #1;
        chk("read low", {8'h00, e[7:0]}, {8'h00, rd_data});
    endtask

    // ==================================================================
    // scenarios
    // ==================================================================
    task automatic t_reset();
        #1;
        for (int i = 0; i < 4; i++)
            chk("param word", 16'h0000, params[16*i +: 16]);
        chk("angle", 16'h0000, electrical_angle);
        rdchk(16'h40cc, 8'h00, 1'b0);
    endtask

    task automatic t_alpha();
        wr16(16'h40c4, 16'h8000);
        chk("alpha", 16'h8000, params.alpha);
        wr16(16'h40c4, 16'h7fff);
        chk("alpha", 16'h7fff, params.alpha);
        rdchk(16'h40c5, 8'h00, 1'b0);
        rdchk(16'h40c4, 8'h00, 1'b0);
        wr(16'h40ce, 8'h55);
        rdchk(16'h40ce, 8'h00, 1'b0);
    endtask

    // range flags follow one cycle after the word completes
    task automatic param_word(input logic [15:0] a, input int k);
        for (int v = 0; v < 5; v++)
        begin
            wr16(a, vals[v]);
            chk("param", vals[v], params[47-16*k -: 16]);
            @(posedge sys_clk);
            #1;
            chk("range flag", {15'h0000, vals_ok[v]}, {15'h0000, oks[2-k]});
        end
    endtask

    task automatic t_params();
        param_word(16'h40c6, 0);
        param_word(16'h40c8, 1);
        param_word(16'h40ca, 2);
    endtask

    // word read back to back, then a lone low read keeps the shadow
    task automatic cur_word(input logic [15:0] a, input int k);
        logic [15:0] cur;
        cur = phase_current[16*k +: 16];
        rd16chk(a, cur, 1'b1);
        rdchk(a + 16'h0001, cur[7:0], 1'b1);
    endtask

    task automatic t_currents();
        @(posedge sys_clk);
        phase_current <= '{a: 16'h8001, b: 16'h7ffe, c: 16'hc35a};
        #1;
        cur_word(16'h40c6, 0);
        cur_word(16'h40c8, 1);
        cur_word(16'h40ca, 2);
    endtask

    task automatic t_angle();
        for (int q = 0; q < 4; q++)
        begin
            wr16(16'h40cc, angs[q]);
            @(posedge sys_clk);
            #1;
            chk("quadrant", 16'(q), {14'h0000, angle_quadrant});
            rdchk(16'h40cc, angs[q][15:8], 1'b0);
            rdchk(16'h40cd, angs[q][7:0], 1'b0);
        end
        @(posedge sys_clk);
        angle_upd <= 1'b1;
        angle_in <= 16'h8000;
        @(posedge sys_clk);
        bus_req <= '{addr: 16'h40cc, wdata: 8'h11, wr: 1'b1, rd: 1'b0};
        angle_in <= 16'h2233;
        #1;
        chk("engine angle", 16'h8000, electrical_angle);
        @(posedge sys_clk);
        angle_upd <= 1'b0;
        bus_req.wr <= 1'b0;
        #1;
        chk("shared update", 16'h1133, electrical_angle);
    endtask

    task automatic complete_run();
        if (num_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==================================================================
    // main sequence, with a second reset in mid-run
    // ==================================================================
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        t_alpha();
        t_params();
        t_currents();
        t_angle();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset();
        complete_run();
    end

    // hang guard
    initial
    begin
        #100us;
        num_errors++;
        complete_run();
    end
endmodule // test_vcp_regs
